//--- src/tpu_unit.v
// Purpose: 10-bit down-counting timer with prescaler, toggle and pwm outputs
// Assumes: clock sources arrive as one-cycle enables or synchronous pins
// Notes:   register read data appear one cycle after the read strobe
`include "tpu_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module tpu_unit (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wr_data,
    input  wire       i_wr_en,
    input  wire       i_rd_en,
    output reg  [7:0] o_rd_data,
    input  wire       i_instr_clk_en,
    input  wire       i_high_osc_en,
    input  wire       i_external_clock_pin,
    input  wire       i_cmp_out,
    input  wire       i_cmp_oe,
    input  wire       i_buzzer1_out,
    input  wire       i_buzzer1_oe,
    output reg        o_shared_output_pad,
    output reg        o_shared_output_pad_oe,
    output reg        o_pwm_pad_a,
    output reg        o_pwm_pad_a_oe,
    output reg        o_pwm_pad_b,
    output reg        o_pwm_pad_b_oe,
    output wire       o_underflow_toggle_out,
    output reg        o_underflow_event
);

    ////////////////////////////////////////////////////////////////////
    // register storage

    reg  [7:0] ctrl_one_reg;
    reg  [7:0] ctrl_two_reg;
    reg  [7:0] reload_low_reg;
    reg  [7:0] reload_high_bits_reg;
    reg  [7:0] duty_low_reg;
    reg  [9:0] count_reg;
    reg  [9:0] count_next;
    reg  [7:0] psc_reg;
    reg  [7:0] psc_next;
    reg        oneshot_done_reg;
    reg        oneshot_done_next;
    reg        toggle_reg;
    reg        raw_prev_reg;
    reg  [7:0] gap_reg;
    reg  [7:0] period_reg;
    reg  [7:0] ext_reg;
    reg  [7:0] ext_next;

    // decode of the write strobe
    wire       wr_count       = i_wr_en & (i_addr == `TPU_A_COUNT_LOW);
    wire       wr_ctrl_one    = i_wr_en & (i_addr == `TPU_A_CTRL_ONE);
    wire       wr_ctrl_two    = i_wr_en & (i_addr == `TPU_A_CTRL_TWO);
    wire       wr_duty        = i_wr_en & (i_addr == `TPU_A_DUTY_LOW);
    wire       wr_reload_high = i_wr_en & (i_addr == `TPU_A_RELOAD_HIGH);

    ////////////////////////////////////////////////////////////////////
    // field extraction

    wire       count_enable;
    wire       reload_select;
    wire       one_shot_select;
    wire       high_osc_clock_select;
    wire       toggle_output_enable;
    wire       pwm_polarity;
    wire       pwm_output_enable;
    wire [2:0] prescaler_rate;
    wire       prescaler_disable_n;
    wire       external_edge_select;
    wire       clock_source_select;
    wire       half_step_duty;
    wire [9:0] reload_value;
    wire [9:0] duty_value;

    assign count_enable          = ctrl_one_reg[`TPU_C1_COUNT_EN];
    assign reload_select         = ctrl_one_reg[`TPU_C1_RELOAD_SEL];
    assign one_shot_select       = ctrl_one_reg[`TPU_C1_ONE_SHOT];
    assign high_osc_clock_select = ctrl_one_reg[`TPU_C1_HIGH_OSC];
    assign toggle_output_enable  = ctrl_one_reg[`TPU_C1_TOGGLE_OE];
    assign pwm_polarity          = ctrl_one_reg[`TPU_C1_PWM_POL];
    assign pwm_output_enable     = ctrl_one_reg[`TPU_C1_PWM_OE];
    assign prescaler_rate        = ctrl_two_reg[`TPU_C2_RATE_MSB:`TPU_C2_RATE_LSB];
    assign prescaler_disable_n   = ctrl_two_reg[`TPU_C2_PSC_DIS_N];
    assign external_edge_select  = ctrl_two_reg[`TPU_C2_EXT_EDGE];
    assign clock_source_select   = ctrl_two_reg[`TPU_C2_CLK_SRC];
    assign half_step_duty        = ctrl_two_reg[`TPU_C2_HALF_STEP];

    // ten-bit values assembled from the high bits and the low bytes
    assign reload_value = {reload_high_bits_reg[`TPU_RH_RELOAD_MSB:`TPU_RH_RELOAD_LSB],
                           reload_low_reg};
    assign duty_value   = {reload_high_bits_reg[`TPU_RH_DUTY_MSB:`TPU_RH_DUTY_LSB],
                           duty_low_reg};

    ////////////////////////////////////////////////////////////////////
    // register writes

    // control writes; the count register write also stores the reload low byte
    always @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_one_reg         <= `TPU_RST_CTRL_ONE;
            ctrl_two_reg         <= `TPU_RST_CTRL_TWO;
            reload_low_reg       <= `TPU_RST_BYTE;
            reload_high_bits_reg <= `TPU_RST_BYTE;
            duty_low_reg         <= `TPU_RST_BYTE;
        end else begin
            if (wr_ctrl_one) begin
                ctrl_one_reg <= i_wr_data & `TPU_C1_RD_MASK;
            end
            if (wr_ctrl_two) begin
                ctrl_two_reg <= i_wr_data & `TPU_C2_WR_MASK;
            end
            if (wr_count) begin
                reload_low_reg <= i_wr_data;
            end
            if (wr_reload_high) begin
                reload_high_bits_reg <= i_wr_data & `TPU_RH_RD_MASK;
            end
            if (wr_duty) begin
                duty_low_reg <= i_wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock source selection

    wire ext_edge;
    wire src_tick;

    tpu_edge u_edge (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_pin     (i_external_clock_pin),
        .i_falling (external_edge_select),
        .o_pulse   (ext_edge)
    );

    // high oscillator overrides, then external pin, then instruction clock
    assign src_tick = high_osc_clock_select ? i_high_osc_en :
                      (clock_source_select ? ext_edge : i_instr_clk_en);

    ////////////////////////////////////////////////////////////////////
    // prescaler

    wire [7:0] psc_mask;
    wire       psc_tick;
    wire       count_tick;

    // code n divides by 2^(n+1): the low n+1 bits must be zero to pass a tick
    // the shift amount is widened so code 7 does not wrap to a zero shift
    assign psc_mask = (`TPU_PSC_ONE << ({1'b0, prescaler_rate} + 4'h1)) - `TPU_PSC_ONE;
    assign psc_tick = src_tick & ((psc_reg & psc_mask) == `TPU_PSC_ZERO);

    // bypassed prescaler passes every source tick straight through
    assign count_tick = count_enable &
                        (prescaler_disable_n ? src_tick : psc_tick);

    // prescaler counts down; a changing rate mid-count can cut a period short,
    // which is why software only retunes it while it is bypassed
    always @* begin
        psc_next = psc_reg;
        if (prescaler_disable_n | ~count_enable) begin
            psc_next = `TPU_RST_PSC;
        end else if (src_tick) begin
            psc_next = psc_reg - `TPU_PSC_ONE;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            psc_reg <= `TPU_RST_PSC;
        end else begin
            psc_reg <= psc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // down counter

    wire underflow;

    // a finished one-shot produces no further underflows
    assign underflow = count_tick & (count_reg == `TPU_CNT_ZERO) & ~oneshot_done_reg;

    // next count: a register write has priority over counting
    always @* begin
        count_next        = count_reg;
        oneshot_done_next = oneshot_done_reg;
        if (wr_count) begin
            count_next        = {reload_high_bits_reg[`TPU_RH_RELOAD_MSB:`TPU_RH_RELOAD_LSB],
                                 i_wr_data};
            oneshot_done_next = 1'b0;
        end else if (~one_shot_select) begin
            oneshot_done_next = 1'b0;
            if (underflow) begin
                count_next = reload_select ? reload_value
                                           : `TPU_CNT_WRAP;
            end else if (count_tick) begin
                count_next = count_reg - `TPU_CNT_ONE;
            end
        end else if (underflow) begin
            oneshot_done_next = 1'b1;
        end else if (count_tick & ~oneshot_done_reg) begin
            count_next = count_reg - `TPU_CNT_ONE;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            count_reg        <= `TPU_RST_CNT;
            oneshot_done_reg <= 1'b0;
        end else begin
            count_reg        <= count_next;
            oneshot_done_reg <= oneshot_done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // underflow event and toggle output

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_underflow_event <= 1'b0;
            toggle_reg        <= 1'b0;
        end else begin
            o_underflow_event <= underflow;
            if (underflow) begin
                toggle_reg <= ~toggle_reg;
            end
        end
    end

    assign o_underflow_toggle_out = toggle_reg;

    ////////////////////////////////////////////////////////////////////
    // pwm generation

    wire pwm_raw;
    wire half_on;
    wire ext_start;
    wire pwm_active;

    // active while the count sits below the duty value inside a frame
    // that runs from the reload value, or from 0x3ff without reload select, down to zero
    assign pwm_raw = count_enable & (count_reg < duty_value);

    // the extension only applies with the high oscillator clock
    assign half_on    = high_osc_clock_select & half_step_duty;
    // the stretch starts in the cycle the raw duty ends, so no low gap opens
    assign ext_start  = half_on & raw_prev_reg & ~pwm_raw & (period_reg > `TPU_GAP_ONE);
    assign pwm_active = pwm_raw | ext_start | (ext_reg != `TPU_PSC_ZERO);

    // measure the tick spacing so half a timer clock can be stretched out;
    // with a tick every cycle the half step rounds down to nothing
    always @(posedge i_clk) begin
        if (i_rst) begin
            gap_reg    <= `TPU_GAP_ONE;
            period_reg <= `TPU_GAP_ONE;
        end else if (count_tick) begin
            period_reg <= gap_reg;
            gap_reg    <= `TPU_GAP_ONE;
        end else if (gap_reg != `TPU_GAP_MAX) begin
            gap_reg <= gap_reg + `TPU_GAP_ONE;
        end
    end

    // extension counter starts when the raw duty ends
    always @* begin
        ext_next = ext_reg;
        if (ext_start) begin
            ext_next = {1'b0, period_reg[7:1]} - `TPU_PSC_ONE;
        end else if (ext_reg != `TPU_PSC_ZERO) begin
            ext_next = ext_reg - `TPU_PSC_ONE;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            raw_prev_reg <= 1'b0;
            ext_reg      <= `TPU_PSC_ZERO;
        end else begin
            raw_prev_reg <= pwm_raw;
            ext_reg      <= ext_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pad outputs

    // pwm pads carry the same waveform; toggle output wins the shared pad
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pwm_pad_a            <= 1'b0;
            o_pwm_pad_a_oe         <= 1'b0;
            o_pwm_pad_b            <= 1'b0;
            o_pwm_pad_b_oe         <= 1'b0;
            o_shared_output_pad    <= 1'b0;
            o_shared_output_pad_oe <= 1'b0;
        end else begin
            o_pwm_pad_a    <= pwm_active ^ pwm_polarity;
            o_pwm_pad_b    <= pwm_active ^ pwm_polarity;
            o_pwm_pad_a_oe <= pwm_output_enable;
            o_pwm_pad_b_oe <= pwm_output_enable;
            if (toggle_output_enable) begin
                o_shared_output_pad    <= toggle_reg;
                o_shared_output_pad_oe <= 1'b1;
            end else if (i_cmp_oe) begin
                o_shared_output_pad    <= i_cmp_out;
                o_shared_output_pad_oe <= 1'b1;
            end else begin
                o_shared_output_pad    <= i_buzzer1_out;
                o_shared_output_pad_oe <= i_buzzer1_oe;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register reads

    // write-only fields and unmapped addresses read as zero
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= `TPU_READ_ZERO;
        end else if (i_rd_en) begin
            case (i_addr)
                `TPU_A_COUNT_LOW:   o_rd_data <= count_reg[7:0];
                `TPU_A_CTRL_ONE:    o_rd_data <= ctrl_one_reg & `TPU_C1_RD_MASK;
                `TPU_A_CTRL_TWO:    o_rd_data <= ctrl_two_reg & `TPU_C2_RD_MASK;
                `TPU_A_PSC_VALUE:   o_rd_data <= psc_reg;
                `TPU_A_RELOAD_HIGH: o_rd_data <= reload_high_bits_reg & `TPU_RH_RD_MASK;
                default:            o_rd_data <= `TPU_READ_ZERO;
            endcase
        end else begin
            o_rd_data <= `TPU_READ_ZERO;
        end
    end

endmodule
`default_nettype wire

//--- src/tpu_regs.vh
// Purpose: register map, field positions and constants of the timer/pwm unit
// Assumes: byte-wide registers on a plain strobe port
// Notes:   definitions only
`ifndef TPU_REGS_VH
`define TPU_REGS_VH

// register addresses
`define TPU_ADDR_W          8
`define TPU_A_COUNT_LOW     8'h10
`define TPU_A_CTRL_ONE      8'h11
`define TPU_A_CTRL_TWO      8'h12
`define TPU_A_DUTY_LOW      8'h13
`define TPU_A_PSC_VALUE     8'h14
`define TPU_A_RELOAD_HIGH   8'h16

// control one fields
`define TPU_C1_COUNT_EN     0
`define TPU_C1_RELOAD_SEL   1
`define TPU_C1_ONE_SHOT     2
`define TPU_C1_HIGH_OSC     3
`define TPU_C1_TOGGLE_OE    5
`define TPU_C1_PWM_POL      6
`define TPU_C1_PWM_OE       7
`define TPU_C1_RD_MASK      8'hef

// control two fields
`define TPU_C2_RATE_LSB     0
`define TPU_C2_RATE_MSB     2
`define TPU_C2_PSC_DIS_N    3
`define TPU_C2_EXT_EDGE     4
`define TPU_C2_CLK_SRC      5
`define TPU_C2_HALF_STEP    6
`define TPU_C2_RD_MASK      8'h3f
`define TPU_C2_WR_MASK      8'h7f

// reload high bits fields
`define TPU_RH_DUTY_LSB     0
`define TPU_RH_DUTY_MSB     1
`define TPU_RH_RELOAD_LSB   4
`define TPU_RH_RELOAD_MSB   5
`define TPU_RH_RD_MASK      8'h33

// reset values
`define TPU_RST_CTRL_ONE    8'h00
`define TPU_RST_CTRL_TWO    8'h3f
`define TPU_RST_BYTE        8'h00
`define TPU_RST_PSC         8'hff
`define TPU_RST_CNT         10'h000

// counter constants
`define TPU_CNT_ZERO        10'h000
`define TPU_CNT_WRAP        10'h3ff
`define TPU_CNT_ONE         10'h001
`define TPU_PSC_ONE         8'h01
`define TPU_PSC_ZERO        8'h00
`define TPU_GAP_ONE         8'h01
`define TPU_GAP_MAX         8'hff
`define TPU_READ_ZERO       8'h00

`endif

//--- src/tpu_edge.v
// Purpose: edge detector for the external count clock pin
// Assumes: pin already synchronous to i_clk
// Notes:   one-cycle pulse on the selected edge
`timescale 1ns/100ps
`default_nettype none

module tpu_edge (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_pin,
    input  wire i_falling,
    output wire o_pulse
);

    reg pin_prev_reg;

    // previous pin level; reset to low, so a pin held high shows a rising edge right after reset
    always @(posedge i_clk) begin
        if (i_rst) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= i_pin;
        end
    end

    // falling when selected, rising otherwise
    assign o_pulse = i_falling ? (pin_prev_reg & ~i_pin)
                               : (~pin_prev_reg & i_pin);

endmodule
`default_nettype wire

//--- tb/tpu_unit_assertions.sv
// Purpose: port-level checks of the timer/pwm unit
// Assumes: one clock, sync active-high reset
// Notes:   bound to every tpu_unit instance
`include "tpu_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module tpu_unit_assertions (
    input wire       i_clk,
    input wire       i_rst,
    input wire [7:0] i_addr,
    input wire [7:0] i_wr_data,
    input wire       i_wr_en,
    input wire       i_rd_en,
    input wire [7:0] o_rd_data,
    input wire       i_cmp_out,
    input wire       i_cmp_oe,
    input wire       o_shared_output_pad,
    input wire       o_shared_output_pad_oe,
    input wire       o_pwm_pad_a,
    input wire       o_pwm_pad_a_oe,
    input wire       o_pwm_pad_b,
    input wire       o_pwm_pad_b_oe,
    input wire       o_underflow_toggle_out,
    input wire       o_underflow_event
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////
    // bus steps: write then read back, read of a write-only or empty place
    sequence s_c1_wr_rd;
        i_wr_en && i_addr == `TPU_A_CTRL_ONE ##1 i_rd_en && i_addr == `TPU_A_CTRL_ONE;
    endsequence
    sequence s_dead_rd;
        i_rd_en && (i_addr == `TPU_A_DUTY_LOW || i_addr == 8'h15);
    endsequence

    a_c1_read_back: assert property (s_c1_wr_rd |=> o_rd_data ==
        ($past(i_wr_data, 2) & `TPU_C1_RD_MASK)) else $error("ctrl one read back wrong");
    a_dead_read_zero: assert property (s_dead_rd |=> o_rd_data == 8'h00)
        else $error("write-only or unmapped read not zero");
    a_rd_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
        else $error("read data outside its cycle");
    a_c2_top_zero: assert property (i_rd_en && i_addr == `TPU_A_CTRL_TWO
        |=> o_rd_data[7:6] == 2'b00) else $error("ctrl two top bits not zero");

    ////////////////////////////////////////
    // the event and the toggle always move together
    a_event_toggles: assert property (o_underflow_event |->
        $changed(o_underflow_toggle_out)) else $error("event without toggle");
    a_toggle_cause: assert property ($changed(o_underflow_toggle_out) |->
        o_underflow_event) else $error("toggle without event");
    a_pwm_pads_same: assert property (o_pwm_pad_a == o_pwm_pad_b &&
        o_pwm_pad_a_oe == o_pwm_pad_b_oe) else $error("pwm pads differ");
    // pad is registered, so it follows last cycle's sources
    a_cmp_holds_pad: assert property (!$past(i_rst) && $past(i_cmp_oe) |->
        o_shared_output_pad_oe) else $error("shared pad released");
    a_toggle_wins: assert property (!$past(i_rst) && $past(i_cmp_oe) &&
        o_shared_output_pad != $past(i_cmp_out) |->
        o_shared_output_pad == $past(o_underflow_toggle_out)) else $error("pad source wrong");
endmodule

bind tpu_unit tpu_unit_assertions u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_cmp_out(i_cmp_out), .i_cmp_oe(i_cmp_oe),
    .o_shared_output_pad(o_shared_output_pad), .o_shared_output_pad_oe(o_shared_output_pad_oe),
    .o_pwm_pad_a(o_pwm_pad_a), .o_pwm_pad_a_oe(o_pwm_pad_a_oe),
    .o_pwm_pad_b(o_pwm_pad_b), .o_pwm_pad_b_oe(o_pwm_pad_b_oe),
    .o_underflow_toggle_out(o_underflow_toggle_out), .o_underflow_event(o_underflow_event));
`default_nettype wire

//--- tb/tpu_pin_model.sv
// Purpose: external count clock pin
// Assumes: pin sampled synchronously by the unit
// Notes:   idles low and stands still between bursts
`timescale 1ns/100ps
`default_nettype none

module tpu_pin_model (
    input  wire  i_clk,
    output logic o_pin
);
    initial o_pin = 1'b0;
    // high held three cycles and low at least four, so a one-cycle edge detector cannot miss it
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (3) @(posedge i_clk);
            o_pin <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench of the timer/pwm unit
// Assumes: 25 MHz clock, register port with read data one cycle later
// Notes:   expectations follow the count and prescaler rules
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wr_data = 8'h00;
    logic       i_wr_en = 1'b0;
    logic       i_rd_en = 1'b0;
    logic       i_instr_clk_en = 1'b0;
    logic       i_high_osc_en = 1'b0;
    logic       i_cmp_out = 1'b0;
    logic       i_cmp_oe = 1'b0;
    logic       i_buz_out = 1'b0;
    logic       i_buz_oe = 1'b0;
    wire        pin;
    wire  [7:0] rd_data;
    wire        sh_pad, sh_oe, pa, pa_oe, pb, pb_oe, tgl, evt;
    int         fail_count = 0;
    int         n_checks = 0;
    int         cycles = 0;

    initial forever #20 i_clk = ~i_clk;

    tpu_pin_model u_pin (.i_clk(i_clk), .o_pin(pin));
    tpu_unit DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(rd_data),
        .i_instr_clk_en(i_instr_clk_en), .i_high_osc_en(i_high_osc_en),
        .i_external_clock_pin(pin), .i_cmp_out(i_cmp_out), .i_cmp_oe(i_cmp_oe),
        .i_buzzer1_out(i_buz_out), .i_buzzer1_oe(i_buz_oe), .o_shared_output_pad(sh_pad),
        .o_shared_output_pad_oe(sh_oe), .o_pwm_pad_a(pa), .o_pwm_pad_a_oe(pa_oe),
        .o_pwm_pad_b(pb), .o_pwm_pad_b_oe(pb_oe), .o_underflow_toggle_out(tgl),
        .o_underflow_event(evt));

    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang would otherwise never report
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    // write then read the same place with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b1;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    // h picks the high oscillator enable instead of the instruction clock
    task automatic tick(input int n, input bit h);
        repeat (n) begin
            @(posedge i_clk);
            if (h) i_high_osc_en <= 1'b1;
            else i_instr_clk_en <= 1'b1;
            @(posedge i_clk);
            i_high_osc_en <= 1'b0;
            i_instr_clk_en <= 1'b0;
        end
    endtask
    task automatic do_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
    endtask

    ////////////////////////////////////////
    task automatic t_reset;
        rd(8'h11, 8'h00);
        rd(8'h12, 8'h3f);
        rd(8'h10, 8'h00);
        rd(8'h13, 8'h00);
        rd(8'h14, 8'hff);
        rd(8'h16, 8'h00);
        rd(8'h15, 8'h00);
        wr_rd(8'h11, 8'h16, 8'h06);
        $display("reset values done");
    endtask
    // 0x101 one-shot: two ticks leave 0x0ff only if the high bits were loaded
    task automatic t_load;
        wr(8'h16, 8'h10);
        wr(8'h10, 8'h01);
        rd(8'h10, 8'h01);
        wr(8'h12, 8'h08);
        wr(8'h11, 8'h05);
        tick(2, 0);
        rd(8'h10, 8'hff);
        wr(8'h11, 8'h04);
        tick(2, 0);
        rd(8'h10, 8'hff);
        wr(8'h16, 8'h00);
        wr(8'h10, 8'h02);
        wr(8'h11, 8'h05);
        tick(5, 0);
        rd(8'h10, 8'h00);
        $display("load and one-shot done");
    endtask
    task automatic t_wrap;
        do_reset();
        wr(8'h12, 8'h08);
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h21);
        i_cmp_oe <= 1'b1;
        i_buz_oe <= 1'b1;
        tick(2, 0);
        #1 chk(evt, 1'b1);
        chk(tgl, 1'b1);
        @(posedge i_clk) #1 chk(evt, 1'b0);
        chk(sh_pad, 1'b1);
        chk(sh_oe, 1'b1);
        rd(8'h10, 8'hff);
        $display("wrap and toggle done");
    endtask
    task automatic t_reload;
        wr(8'h10, 8'h03);
        wr(8'h11, 8'h03);
        tick(4, 0);
        rd(8'h10, 8'h03);
        tick(1, 0);
        rd(8'h10, 8'h02);
        $display("reload done");
    endtask
    task automatic t_ext;
        wr(8'h12, 8'h28);
        wr(8'h10, 8'h10);
        wr(8'h11, 8'h01);
        u_pin.pulse(3);
        rd(8'h10, 8'h0d);
        tick(2, 0);
        rd(8'h10, 8'h0d);
        wr(8'h12, 8'h38);
        u_pin.pulse(2);
        rd(8'h10, 8'h0b);
        wr(8'h11, 8'h09);
        u_pin.pulse(2);
        tick(2, 0);
        rd(8'h10, 8'h0b);
        tick(3, 1);
        rd(8'h10, 8'h08);
        $display("clock sources done");
    endtask
    // 2n ticks from the reset value 0xff hold exactly two prescaler passes
    task automatic t_psc;
        logic [7:0] e;
        for (int r = 0; r < 8; r++) begin
            e = 8'hff - 8'(4 << r);
            wr(8'h11, 8'h00);
            wr(8'h12, 8'h08 | 8'(r));
            rd(8'h14, 8'hff);
            wr(8'h12, 8'(r));
            wr(8'h10, 8'h80);
            wr(8'h11, 8'h01);
            tick(4 << r, 0);
            rd(8'h10, 8'h7e);
            rd(8'h14, e);
            wr(8'h12, 8'h08 | 8'(r));
        end
        $display("prescaler done");
    endtask
    task automatic t_pwm;
        wr(8'h16, 8'h03);
        wr(8'h13, 8'hff);
        wr(8'h11, 8'h81);
        repeat (2) @(posedge i_clk);
        #1 chk(pa, 1'b1);
        chk(pa_oe, 1'b1);
        wr(8'h11, 8'hc1);
        repeat (2) @(posedge i_clk);
        #1 chk(pa, 1'b0);
        wr(8'h16, 8'h00);
        wr(8'h13, 8'h00);
        repeat (2) @(posedge i_clk);
        #1 chk(pa, 1'b1);
        wr(8'h11, 8'h41);
        repeat (2) @(posedge i_clk);
        #1 chk(pa_oe, 1'b0);
        $display("pwm done");
    endtask
    // duty ends at underflow; the stretch shows only on the high oscillator
    task automatic t_half;
        wr(8'h12, 8'h48);
        wr(8'h13, 8'h02);
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h89);
        tick(2, 1);
        @(posedge i_clk) #1 chk(pa, 1'b1);
        @(posedge i_clk) #1 chk(pa, 1'b0);
        wr(8'h11, 8'h81);
        wr(8'h10, 8'h01);
        tick(2, 0);
        @(posedge i_clk) #1 chk(pa, 1'b0);
        $display("half step done");
    endtask

    initial begin
        do_reset();
        t_reset();
        t_load();
        t_wrap();
        t_reload();
        t_ext();
        t_psc();
        t_pwm();
        t_half();
        tally_and_finish();
    end
endmodule
`default_nettype wire
